// [rtl/rsb_pkg.sv]
// constants shared by both ends of the register-space byte link
package rsb_pkg;
	localparam int BYTE_W = 8;
	localparam int WORD_W = 16;
	localparam int CMD_W = 48;
	localparam int CMD_EDGES = CMD_W / BYTE_W;
	localparam int WORD_EDGES = WORD_W / BYTE_W;
	localparam int CMD_RD_BIT = 47;
	localparam int CMD_SPACE_BIT = 46;
	localparam int ADDR_W = 46;
	localparam int SYNC_N = 3;
	localparam int DEF_LAT = 4;
	localparam int CORE_CLK_MHZ = 200;
	localparam int LINK_HALF_NS = 40;
	localparam int LINK_HALF_CYC = (LINK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int MIN_HALF_CYC = 8;
	localparam logic [BYTE_W-1:0] BUS_IDLE = 8'h00;
endpackage

// [rtl/rsb_link_if.sv]
// link wires between the bus master end and the device end
interface rsb_link_if;
	logic cs_n;
	logic host_bus_clock;
	logic [rsb_pkg::BYTE_W-1:0] host_dq;
	logic host_dq_oe;
	logic [rsb_pkg::BYTE_W-1:0] dev_dq;
	logic dev_dq_oe;
	logic dev_dsm;
	logic dev_dsm_oe;
	logic [rsb_pkg::BYTE_W-1:0] dq;
	logic data_strobe_mask;

	// undriven wires settle low, as a weak pull-down would hold them
	assign dq = dev_dq_oe ? dev_dq :
		(host_dq_oe ? host_dq : rsb_pkg::BUS_IDLE);
	assign data_strobe_mask = dev_dsm_oe ? dev_dsm : 1'b0;

	modport host (
		output cs_n,
		output host_bus_clock,
		output host_dq,
		output host_dq_oe,
		input dq,
		input data_strobe_mask
	);
	modport device (
		input cs_n,
		input host_bus_clock,
		input dq,
		output dev_dq,
		output dev_dq_oe,
		output dev_dsm,
		output dev_dsm_oe
	);
endinterface

// [rtl/rsb_dev.sv]
// device end: register-space word capture and read-out on the link
module rsb_dev #(
	parameter int LAT = rsb_pkg::DEF_LAT
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	rsb_link_if.device link,
	output logic rd_req_o,
	output logic wr_o,
	output logic [rsb_pkg::CMD_W-1:0] cmd_o,
	output logic [rsb_pkg::WORD_W-1:0] wr_data_o,
	input wire logic [rsb_pkg::WORD_W-1:0] rd_data_i
);

	if (LAT < 1 || LAT > 255) begin
		$error("rsb_dev: LAT must lie in 1..255");
	end

	typedef enum logic [2:0] {
		D_IDLE,
		D_CMD,
		D_WR,
		D_LAT,
		D_RD,
		D_SKIP
	} rsb_dst_t;

	typedef struct packed {
		rsb_dst_t st;
		logic [rsb_pkg::SYNC_N-1:0] lclk_s;
		logic lclk_q;
		logic [rsb_pkg::SYNC_N-1:0] cs_s;
		logic cs_q;
		logic [rsb_pkg::SYNC_N-1:0][rsb_pkg::BYTE_W-1:0] dq_s;
		logic [rsb_pkg::BYTE_W-1:0] dq_q;
		logic [3:0] ecnt;
		logic [7:0] lcnt;
		logic [rsb_pkg::CMD_W-1:0] cmd;
		logic [rsb_pkg::WORD_W-1:0] word;
		logic [rsb_pkg::BYTE_W-1:0] dq_o;
		logic dq_oe;
		logic dsm;
		logic dsm_oe;
		logic rd_req;
		logic wr;
	} rsb_dev_state_t;

	localparam rsb_dev_state_t RST = '{
		st: D_IDLE,
		lclk_s: '0,
		lclk_q: 1'b0,
		cs_s: '1,
		cs_q: 1'b1,
		dq_s: '0,
		dq_q: '0,
		ecnt: '0,
		lcnt: '0,
		cmd: '0,
		word: '0,
		dq_o: '0,
		dq_oe: 1'b0,
		dsm: 1'b0,
		dsm_oe: 1'b0,
		rd_req: 1'b0,
		wr: 1'b0
	};

	localparam logic [3:0] CMD_LAST = 4'(rsb_pkg::CMD_EDGES - 1);
	localparam logic [7:0] LAT_N = 8'(LAT);

	rsb_dev_state_t s_ff;
	rsb_dev_state_t nxt_s;

	logic lclk_agree;
	logic rise;
	logic fall;
	logic [rsb_pkg::BYTE_W-1:0] dq_now;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.rd_req = 1'b0;
		nxt_s.wr = 1'b0;

		// three-stage pin synchronisers; only stages two and three decide
		nxt_s.lclk_s = {s_ff.lclk_s[1:0], link.host_bus_clock};
		nxt_s.cs_s = {s_ff.cs_s[1:0], link.cs_n};
		nxt_s.dq_s = {s_ff.dq_s[1:0], link.dq};

		lclk_agree = s_ff.lclk_s[1] == s_ff.lclk_s[2];
		rise = lclk_agree && s_ff.lclk_s[1] && !s_ff.lclk_q;
		fall = lclk_agree && !s_ff.lclk_s[1] && s_ff.lclk_q;
		if (lclk_agree) begin
			nxt_s.lclk_q = s_ff.lclk_s[1];
		end
		if (s_ff.cs_s[1] == s_ff.cs_s[2]) begin
			nxt_s.cs_q = s_ff.cs_s[1];
		end
		if (s_ff.dq_s[1] == s_ff.dq_s[2]) begin
			dq_now = s_ff.dq_s[1];
		end else begin
			dq_now = s_ff.dq_q;
		end
		nxt_s.dq_q = dq_now;

		if (s_ff.cs_q) begin
			// deselect ends any access and frees both wires
			nxt_s.st = D_IDLE;
			nxt_s.ecnt = '0;
			nxt_s.lcnt = '0;
			nxt_s.dq_oe = 1'b0;
			nxt_s.dsm_oe = 1'b0;
			nxt_s.dsm = 1'b0;
		end else begin
			case (s_ff.st)
				D_IDLE: begin
					nxt_s.st = D_CMD;
					nxt_s.ecnt = '0;
				end
				D_CMD: begin
					if (rise || fall) begin
						// command word arrives high byte first
						nxt_s.cmd = {s_ff.cmd[rsb_pkg::CMD_W-9:0], dq_now};
						nxt_s.ecnt = s_ff.ecnt + 4'h1;
						if (s_ff.ecnt == CMD_LAST) begin
							nxt_s.ecnt = '0;
							nxt_s.lcnt = '0;
							if (!nxt_s.cmd[rsb_pkg::CMD_SPACE_BIT]) begin
								// memory space is served elsewhere
								nxt_s.st = D_SKIP;
							end else if (nxt_s.cmd[rsb_pkg::CMD_RD_BIT]) begin
								nxt_s.rd_req = 1'b1;
								nxt_s.st = D_LAT;
							end else begin
								nxt_s.st = D_WR;
							end
						end
					end
				end
				D_WR: begin
					// no latency on register writes: word follows at once
					if (rise) begin
						nxt_s.word[15:8] = dq_now;
					end else if (fall) begin
						nxt_s.word[7:0] = dq_now;
						nxt_s.wr = 1'b1;
						nxt_s.st = D_SKIP;
					end
				end
				D_LAT: begin
					if (rise) begin
						if (s_ff.lcnt == LAT_N) begin
							// user word is sampled here, on the (LAT+1)th rise after request
							nxt_s.word = rd_data_i;
							nxt_s.dq_o = rd_data_i[15:8];
							nxt_s.dq_oe = 1'b1;
							nxt_s.dsm = 1'b1;
							nxt_s.dsm_oe = 1'b1;
							nxt_s.st = D_RD;
						end else begin
							nxt_s.lcnt = s_ff.lcnt + 8'h01;
						end
					end
				end
				D_RD: begin
					// the word repeats while the host keeps clocking
					if (rise) begin
						nxt_s.dq_o = s_ff.word[15:8];
						nxt_s.dsm = 1'b1;
					end else if (fall) begin
						nxt_s.dq_o = s_ff.word[7:0];
						nxt_s.dsm = 1'b0;
					end
					nxt_s.dsm_oe = 1'b1;
				end
				D_SKIP: begin
					nxt_s.st = D_SKIP;
				end
				default: begin
					nxt_s.st = D_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_ff <= RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign link.dev_dq = s_ff.dq_o;
	assign link.dev_dq_oe = s_ff.dq_oe;
	assign link.dev_dsm = s_ff.dsm;
	assign link.dev_dsm_oe = s_ff.dsm_oe;
	assign rd_req_o = s_ff.rd_req;
	assign wr_o = s_ff.wr;
	assign cmd_o = s_ff.cmd;
	assign wr_data_o = s_ff.word;

endmodule

// [rtl/rsb_host.sv]
// bus master end: frames one register access and makes the link clock
module rsb_host #(
	parameter int LAT = rsb_pkg::DEF_LAT,
	parameter int HALF = rsb_pkg::LINK_HALF_CYC
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	rsb_link_if.host link,
	input wire logic req_i,
	input wire logic read_i,
	input wire logic reg_space_i,
	input wire logic [rsb_pkg::ADDR_W-1:0] addr_i,
	input wire logic [rsb_pkg::WORD_W-1:0] wr_data_i,
	output logic busy_o,
	output logic done_o,
	output logic rd_valid_o,
	output logic [rsb_pkg::WORD_W-1:0] rd_data_o
);

	if (HALF < rsb_pkg::MIN_HALF_CYC || HALF > 127 || HALF % 2 != 0) begin
		$error("rsb_host: HALF must be even and in 8..126");
	end
	if (LAT < 1 || LAT > 100) begin
		$error("rsb_host: LAT must lie in 1..100");
	end

	typedef enum logic [1:0] {
		H_IDLE,
		H_LEAD,
		H_CLK,
		H_TAIL
	} rsb_hst_t;

	localparam int SH_W = rsb_pkg::CMD_W + rsb_pkg::WORD_W;

	typedef struct packed {
		rsb_hst_t st;
		logic [7:0] hc;
		logic [7:0] ecnt;
		logic [7:0] nedge;
		logic [SH_W-1:0] sh;
		logic rd;
		logic lclk;
		logic cs_n;
		logic [rsb_pkg::BYTE_W-1:0] dq_o;
		logic dq_oe;
		logic [rsb_pkg::SYNC_N-1:0] ds_s;
		logic ds_q;
		logic [rsb_pkg::SYNC_N-1:0][rsb_pkg::BYTE_W-1:0] dq_s;
		logic [rsb_pkg::BYTE_W-1:0] dq_q;
		logic [rsb_pkg::WORD_W-1:0] rdw;
		logic busy;
		logic done;
		logic rd_valid;
	} rsb_host_state_t;

	localparam rsb_host_state_t RST = '{
		st: H_IDLE,
		hc: '0,
		ecnt: '0,
		nedge: '0,
		sh: '0,
		rd: 1'b0,
		lclk: 1'b0,
		cs_n: 1'b1,
		dq_o: '0,
		dq_oe: 1'b0,
		ds_s: '0,
		ds_q: 1'b0,
		dq_s: '0,
		dq_q: '0,
		rdw: '0,
		busy: 1'b0,
		done: 1'b0,
		rd_valid: 1'b0
	};

	localparam logic [7:0] HALF_END = 8'(HALF - 1);
	localparam logic [7:0] HALF_MID = 8'(HALF / 2 - 1);
	localparam logic [7:0] TAIL_END = 8'(2 * HALF - 1);
	localparam logic [7:0] CMD_N = 8'(rsb_pkg::CMD_EDGES);
	localparam logic [7:0] WR_N =
		8'(rsb_pkg::CMD_EDGES + rsb_pkg::WORD_EDGES);
	localparam logic [7:0] RD_N =
		8'(rsb_pkg::CMD_EDGES + 2 * LAT + rsb_pkg::WORD_EDGES);

	rsb_host_state_t s_ff;
	rsb_host_state_t nxt_s;

	logic ds_agree;
	logic [rsb_pkg::BYTE_W-1:0] dq_now;

	always_comb begin
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.rd_valid = 1'b0;

		nxt_s.ds_s = {s_ff.ds_s[1:0], link.data_strobe_mask};
		nxt_s.dq_s = {s_ff.dq_s[1:0], link.dq};
		ds_agree = s_ff.ds_s[1] == s_ff.ds_s[2];
		if (s_ff.dq_s[1] == s_ff.dq_s[2]) begin
			dq_now = s_ff.dq_s[1];
		end else begin
			dq_now = s_ff.dq_q;
		end
		nxt_s.dq_q = dq_now;
		if (ds_agree) begin
			nxt_s.ds_q = s_ff.ds_s[1];
		end

		// read data is taken on the strobe edges, high byte first
		if (s_ff.busy && s_ff.rd && ds_agree) begin
			if (s_ff.ds_s[1] && !s_ff.ds_q) begin
				nxt_s.rdw[15:8] = dq_now;
			end else if (!s_ff.ds_s[1] && s_ff.ds_q) begin
				nxt_s.rdw[7:0] = dq_now;
			end
		end

		case (s_ff.st)
			H_IDLE: begin
				if (req_i) begin
					// bit 47 read, bit 46 space select
					nxt_s.sh = {read_i, reg_space_i, addr_i, wr_data_i};
					nxt_s.rd = read_i;
					nxt_s.nedge = read_i ? RD_N : WR_N;
					nxt_s.dq_o = nxt_s.sh[SH_W-1 -: 8];
					nxt_s.dq_oe = 1'b1;
					nxt_s.cs_n = 1'b0;
					nxt_s.lclk = 1'b0;
					nxt_s.hc = '0;
					nxt_s.ecnt = '0;
					nxt_s.rdw = '0;
					nxt_s.busy = 1'b1;
					nxt_s.st = H_LEAD;
				end
			end
			H_LEAD: begin
				nxt_s.hc = s_ff.hc + 8'h01;
				if (s_ff.hc == HALF_END) begin
					nxt_s.hc = '0;
					nxt_s.lclk = 1'b1;
					nxt_s.ecnt = 8'h01;
					nxt_s.st = H_CLK;
				end
			end
			H_CLK: begin
				nxt_s.hc = s_ff.hc + 8'h01;
				// data moves mid-way between edges, centred on them
				if (s_ff.hc == HALF_MID) begin
					if (s_ff.ecnt == s_ff.nedge ||
						(s_ff.rd && s_ff.ecnt >= CMD_N)) begin
						nxt_s.dq_oe = 1'b0;
					end else begin
						// word high byte meets the rise, low byte the fall
						nxt_s.sh = {s_ff.sh[SH_W-9:0], 8'h00};
						nxt_s.dq_o = s_ff.sh[SH_W-9 -: 8];
					end
				end
				if (s_ff.hc == HALF_END) begin
					nxt_s.hc = '0;
					if (s_ff.ecnt == s_ff.nedge) begin
						nxt_s.st = H_TAIL;
					end else begin
						nxt_s.lclk = !s_ff.lclk;
						nxt_s.ecnt = s_ff.ecnt + 8'h01;
					end
				end
			end
			H_TAIL: begin
				// clock idles low; deselect leaves the device time to let go
				nxt_s.hc = s_ff.hc + 8'h01;
				if (s_ff.hc == HALF_END) begin
					nxt_s.cs_n = 1'b1;
				end
				if (s_ff.hc == TAIL_END) begin
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.rd_valid = s_ff.rd;
					nxt_s.st = H_IDLE;
				end
			end
			default: begin
				nxt_s.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s_ff <= RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign link.cs_n = s_ff.cs_n;
	assign link.host_bus_clock = s_ff.lclk;
	assign link.host_dq = s_ff.dq_o;
	assign link.host_dq_oe = s_ff.dq_oe;
	assign busy_o = s_ff.busy;
	assign done_o = s_ff.done;
	assign rd_valid_o = s_ff.rd_valid;
	assign rd_data_o = s_ff.rdw;

endmodule

// [test/rsb_link_sva.sv]
// link protocol assertions for the register-space byte link
module rsb_link_sva (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic cs_n,
	input wire logic host_bus_clock,
	input wire logic [7:0] host_dq,
	input wire logic host_dq_oe,
	input wire logic [7:0] dev_dq,
	input wire logic dev_dq_oe,
	input wire logic dev_dsm,
	input wire logic dev_dsm_oe,
	input wire logic [7:0] dq,
	input wire logic data_strobe_mask
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	logic first_ff;
	logic mem_ff;
	// space bit is the second bit of the first byte, taken at the first rise
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			first_ff <= 1'b1;
			mem_ff <= 1'b0;
		end else if (cs_n) begin
			// each frame decides its space afresh
			first_ff <= 1'b1;
			mem_ff <= 1'b0;
		end else if (first_ff && $rose(host_bus_clock)) begin
			first_ff <= 1'b0;
			mem_ff <= !dq[6];
		end
	end
	sequence s_rise;
		dev_dq_oe && $rose(dev_dsm);
	endsequence
	sequence s_fall;
		dev_dq_oe && $fell(dev_dsm);
	endsequence
	chk_no_fight:
		assert property (!(host_dq_oe && dev_dq_oe)) else $error("dq fight");
	chk_strobe_with_data:
		assert property (dev_dq_oe |->
			dev_dsm_oe && data_strobe_mask == dev_dsm)
		else $error("strobe not driven");
	chk_word_per_cycle:
		assert property (s_rise |-> ##[6:10] $fell(dev_dsm))
		else $error("no low byte");
	chk_high_on_rise:
		assert property (s_rise |-> host_bus_clock && $past(host_bus_clock, 2))
		else $error("high byte off clock rise");
	chk_low_on_fall:
		assert property (s_fall |-> !host_bus_clock && !$past(host_bus_clock, 2))
		else $error("low byte off clock fall");
	chk_read_edge_aligned:
		assert property (dev_dq_oe && $past(dev_dq_oe) && $changed(dev_dq)
			|-> $changed(dev_dsm)) else $error("read data off strobe");
	chk_write_centred:
		assert property (host_dq_oe && $past(host_dq_oe) && $changed(host_dq)
			|-> $past(host_bus_clock, 4) != $past(host_bus_clock, 5))
		else $error("write data not centred");
	chk_mem_quiet:
		assert property (mem_ff |-> !dev_dq_oe && !dev_dsm_oe)
		else $error("device drives in memory space");
endmodule

// [test/tb_register_space_byte_order.sv]
// self-checking bench: host and device ends joined over the link
module tb_register_space_byte_order;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int LAT = 2;
	localparam int HALF = rsb_pkg::LINK_HALF_CYC;
	logic core_clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic req, rd, rs, busy, done, rv, rreq, wr;
	logic [45:0] addr;
	logic [15:0] wdat, rdat, seed, rdo, wdo;
	logic [47:0] cao;
	int n_errors = 0;
	int n_compared = 0;
	int n_wr = 0;
	int n_rr = 0;
	logic [7:0] wq[$];
	logic [7:0] rq[$];
	rsb_link_if link();
	rsb_host #(.LAT(LAT), .HALF(HALF)) rsb_host_i (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .link(link.host), .req_i(req), .read_i(rd),
		.reg_space_i(rs), .addr_i(addr), .wr_data_i(wdat), .busy_o(busy),
		.done_o(done), .rd_valid_o(rv), .rd_data_o(rdo));
	rsb_dev #(.LAT(LAT)) rsb_dev_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.link(link.device), .rd_req_o(rreq), .wr_o(wr), .cmd_o(cao),
		.wr_data_o(wdo), .rd_data_i(rdat));
	rsb_link_sva rsb_link_sva_i (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
		.cs_n(link.cs_n), .host_bus_clock(link.host_bus_clock),
		.host_dq(link.host_dq), .host_dq_oe(link.host_dq_oe),
		.dev_dq(link.dev_dq), .dev_dq_oe(link.dev_dq_oe),
		.dev_dsm(link.dev_dsm), .dev_dsm_oe(link.dev_dsm_oe), .dq(link.dq),
		.data_strobe_mask(link.data_strobe_mask));
	always #2.5 core_clk_i = ~core_clk_i;
	// bytes seen on the wire at each link edge while the host drives, and at each strobe edge while the device drives
	always @(posedge core_clk_i) begin
		if (wr)
			n_wr++;
		if (rreq)
			n_rr++;
		if (link.host_dq_oe && $changed(link.host_bus_clock))
			wq.push_back(link.dq);
		if (link.dev_dq_oe && $changed(link.dev_dsm))
			rq.push_back(link.dq);
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// req held high past the taken edge must be ignored while busy
	task automatic access(input logic r, input logic s, input int hold);
		int k;
		int w0;
		int q0;
		seed = lfsr(seed);
		addr = {seed[13:0], seed, ~seed};
		seed = lfsr(seed);
		wdat = seed;
		rdat = ~seed;
		rd = r;
		rs = s;
		w0 = n_wr;
		q0 = n_rr;
		wq.delete();
		rq.delete();
		req = 1'b1;
		k = -1;
		do begin
			@(posedge core_clk_i);
			#1;
			k++;
			if (k == 0)
				chk(busy, 1'b1);
			if (k == hold)
				req = 1'b0;
		end while (done !== 1'b1 && k < 400);
		// lead half, one half per link edge, two halves of tail
		chk(k, HALF * (11 + (r ? 2 * LAT : 0)));
		chk(busy, 1'b0);
		chk(rv, r);
		chk(wq.size(), r ? 6 : 8);
		chk({wq[0], wq[1], wq[2], wq[3], wq[4], wq[5]}, {r, s, addr});
		chk(n_wr - w0, !r && s);
		chk(n_rr - q0, r && s);
		if (s)
			chk(cao, {r, s, addr});
		if (!r) begin
			chk(wq[6], wdat[15:8]);
			chk(wq[7], wdat[7:0]);
			if (s)
				chk(wdo, wdat);
		end else begin
			chk(rdo, s ? rdat : 16'h0000);
			chk(rq.size(), s ? 2 : 0);
			if (s)
				chk({rq[0], rq[1]}, rdat);
		end
	endtask
	initial begin
		req = 1'b0;
		rd = 1'b0;
		rs = 1'b0;
		addr = '0;
		wdat = '0;
		rdat = '0;
		seed = 16'hF0CE;
		repeat (16) @(posedge core_clk_i);
		#1;
		rstn_i = 1'b1;
		for (int i = 0; i < 4; i++)
			access(i[1], i[0], i);
		$display("test modes done");
		for (int i = 0; i < 24; i++)
			access(seed[0], seed[1], seed[3:2]);
		$display("test random done");
		tally_and_finish();
	end
	initial begin
		#50000;
		n_errors++;
		tally_and_finish();
	end
endmodule
